// >>> design/gpp_pkg.sv
// Constants and carrier types of the port pin logic.
// Assumes a 32-bit AHB-Lite slave on a single 20 MHz clock.
package gpp_pkg;
	// ****************************************
	// Register indices, byte address = 4 * index
	// ****************************************
	localparam logic [7:0] IDX_A_DATA = 8'h05;
	localparam logic [7:0] IDX_B_DATA = 8'h06;
	localparam logic [7:0] IDX_INTCTL = 8'h0b;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_A_DIR = 8'h85;
	localparam logic [7:0] IDX_B_DIR = 8'h86;
	localparam logic [7:0] IDX_ANALOG_SELECT = 8'h91;
	localparam logic [7:0] IDX_WPU = 8'h95;
	localparam logic [7:0] IDX_IOC = 8'h96;
	localparam logic [7:0] IDX_OSCSEL = 8'ha0;
	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_ANALOG_SELECT = 8'hff;
	localparam logic [7:0] RST_WPU = 8'hff;
	localparam logic [3:0] RST_IOC = 4'h0;
	localparam logic [7:0] RST_LAT = 8'h00;
	localparam int OPT_PU_DIS = 7;
	localparam int OPT_EDGE = 6;
	localparam int IC_CHG_F = 0;
	localparam int IC_EXT_F = 1;
	localparam int IC_CHG_E = 3;
	localparam int IC_EXT_E = 4;
	localparam int OSC6_LO = 0;
	localparam int OSC7_LO = 2;
	localparam int IOC_LO = 4;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		OSC_GPIO,
		OSC_XTAL,
		OSC_CLK,
		OSC_TMR
	} gpp_osc_e;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} gpp_pin_s;
	typedef struct packed {
		logic [7:0] own;
		logic [7:0] val;
		logic [7:0] hiz;
	} gpp_lcd_s;
endpackage : gpp_pkg

// >>> design/gpp_port_logic.sv
// Two-port pin logic: first port data/direction/analog select
// with oscillator pins, second port pull-ups, change detect, INT pin.
// Assumes pin inputs asynchronous to hclk, one AHB-Lite master,
// hresetn is power-on reset and warm_rst a clocked master-clear/BOR.
//
// Summary of operation
// - First port pin 6: I/O, crystal, clock out or timer osc out.
// - First port pin 7: I/O, crystal, clock in or timer osc in.
// - Each second port pin has its own pull-up enable bit.
// - Pull-up off whenever the pin is an output.
// - Power-on reset sets global pull-up disable, option bit 7.
// - Change detect only on second port pins 7 to 4, per-pin enable.
// - Power-on reset clears all change enables.
// - Enabled pins compare with latch captured at last port read or write.
// - Mismatches ORed set the port change flag.
// - Port change may wake the device from sleep.
// - Port access ends the mismatch, then software clears the flag.
// - Persisting mismatch keeps setting the flag.
// - Last-read latch survives warm resets; flag re-sets on mismatch.
// - A change coinciding with the read sample may be missed.
// - Second port pins 7 and 6 carry programming data and clock.
// - Second port pin 0 is an external edge interrupt input.
// - Display drive goes straight to pins, tri-state as it says.
// - Direction 1 makes a pin input, 0 drives the latch.
// - Port reads return pin levels; writes load the output latch.
// - Analog-selected pins read as zero.
// - Pull-up needs the global enable as well.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module gpp_port_logic
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic warm_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] a_pin_in,
	output gpp_pkg::gpp_pin_s a_pin,
	input wire logic [7:0] b_pin_in,
	output gpp_pkg::gpp_pin_s b_pin,
	output logic [7:0] b_pullup,
	input wire gpp_pkg::gpp_lcd_s a_lcd,
	input wire gpp_pkg::gpp_lcd_s b_lcd,
	input wire logic clk_out_src,
	input wire logic prog_mode,
	input wire logic prog_data_out,
	input wire logic prog_data_drive,
	output logic prog_data_in,
	output logic prog_clk,
	output logic osc_in_level,
	output logic wake
);
	import gpp_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] a_lat;
		logic [7:0] a_dir;
		logic [7:0] analog_select;
		logic [7:0] opt;
		logic [7:0] b_lat;
		logic [7:0] b_dir;
		logic [7:0] wpu;
		logic [3:0] ioc;
		logic [3:0] osc;
		logic chg_f;
		logic ext_f;
		logic chg_e;
		logic ext_e;
		logic [3:0] last_rd;
		logic [7:0] a_s1;
		logic [7:0] a_s2;
		logic [7:0] b_s1;
		logic [7:0] b_s2;
		logic b0_prev;
		logic pend_rd;
		logic pend_wr;
		logic [7:0] idx;
		logic [7:0] rdata;
		logic ready;
		gpp_pin_s a_pin;
		gpp_pin_s b_pin;
		logic [7:0] pu;
		logic pdi;
		logic pclk;
		logic oscin;
		logic wake;
	} gpp_state_s;

	gpp_state_s st_reg;
	gpp_state_s st_next;

	localparam gpp_state_s ST_RST = '{
		a_lat: RST_LAT,
		a_dir: RST_DIR,
		analog_select: RST_ANALOG_SELECT,
		opt: RST_OPTION,
		b_lat: RST_LAT,
		b_dir: RST_DIR,
		wpu: RST_WPU,
		ioc: RST_IOC,
		osc: 4'h0,
		chg_f: 1'b0,
		ext_f: 1'b0,
		chg_e: 1'b0,
		ext_e: 1'b0,
		last_rd: 4'h0,
		a_s1: 8'h00,
		a_s2: 8'h00,
		b_s1: 8'h00,
		b_s2: 8'h00,
		b0_prev: 1'b0,
		pend_rd: 1'b0,
		pend_wr: 1'b0,
		idx: 8'h00,
		rdata: 8'h00,
		ready: 1'b1,
		a_pin: '{out: 8'h00, oe_n: 8'hff},
		b_pin: '{out: 8'h00, oe_n: 8'hff},
		pu: 8'h00,
		pdi: 1'b0,
		pclk: 1'b0,
		oscin: 1'b0,
		wake: 1'b0
	};

	gpp_osc_e mode6;
	gpp_osc_e mode7;
	logic [7:0] a_rd;
	logic [7:0] a_dir_rd;
	logic [7:0] b_rd;
	logic [7:0] rmux;
	logic [7:0] wd;
	logic acc;
	logic mism;
	logic edge_hit;
	logic wr_b;
	logic rd_b;

	assign mode6 = gpp_osc_e'(st_reg.osc[OSC6_LO +: 2]);
	assign mode7 = gpp_osc_e'(st_reg.osc[OSC7_LO +: 2]);
	assign wd = hwdata[7:0];
	assign acc = hsel && htrans[1] && hready;

	// ****************************************
	// Read views of ports
	// ****************************************
	always_comb
	begin
		a_rd = st_reg.a_s2;
		a_rd[3:0] = a_rd[3:0] & ~st_reg.analog_select[3:0];
		a_rd[5] = a_rd[5] & ~st_reg.analog_select[4];
		a_dir_rd = st_reg.a_dir;
		// Oscillator owned pins read low and show as inputs
		if (mode6 != OSC_GPIO)
		begin
			a_rd[6] = 1'b0;
			a_dir_rd[6] = 1'b1;
		end
		if (mode7 != OSC_GPIO)
		begin
			a_rd[7] = 1'b0;
			a_dir_rd[7] = 1'b1;
		end
		b_rd = st_reg.b_s2;
	end

	always_comb
	begin
		unique case (st_reg.idx)
			IDX_A_DATA: rmux = a_rd;
			IDX_B_DATA: rmux = b_rd;
			IDX_INTCTL: rmux = {3'h0, st_reg.ext_e, st_reg.chg_e, 1'b0,
				st_reg.ext_f, st_reg.chg_f};
			IDX_OPTION: rmux = st_reg.opt;
			IDX_A_DIR: rmux = a_dir_rd;
			IDX_B_DIR: rmux = st_reg.b_dir;
			IDX_ANALOG_SELECT: rmux = st_reg.analog_select;
			IDX_WPU: rmux = st_reg.wpu;
			IDX_IOC: rmux = {st_reg.ioc, 4'h0};
			IDX_OSCSEL: rmux = {4'h0, st_reg.osc};
			default: rmux = 8'h00;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		st_next = st_reg;
		// Two stages keep pin metastability off the compare
		st_next.a_s1 = a_pin_in;
		st_next.a_s2 = st_reg.a_s1;
		st_next.b_s1 = b_pin_in;
		st_next.b_s2 = st_reg.b_s1;
		st_next.b0_prev = st_reg.b_s2[0];

		// Bus: reads take one wait state, writes none
		wr_b = st_reg.pend_wr && st_reg.idx == IDX_B_DATA;
		rd_b = st_reg.pend_rd && st_reg.idx == IDX_B_DATA;
		st_next.pend_wr = 1'b0;
		st_next.pend_rd = 1'b0;
		st_next.ready = 1'b1;
		if (st_reg.pend_rd)
		begin
			st_next.rdata = rmux;
		end
		if (acc)
		begin
			st_next.idx = (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hff;
			st_next.pend_wr = hwrite;
			st_next.pend_rd = !hwrite;
			st_next.ready = hwrite;
		end

		// Any second port data read or write refreshes the compare latch;
		// a pin moving at the same sample may go unseen
		if (wr_b || rd_b)
		begin
			st_next.last_rd = st_reg.b_s2[7:4];
		end

		// Register writes
		if (st_reg.pend_wr)
		begin
			unique case (st_reg.idx)
				IDX_A_DATA: st_next.a_lat = wd;
				IDX_B_DATA: st_next.b_lat = wd;
				IDX_INTCTL:
				begin
					st_next.chg_e = wd[IC_CHG_E];
					st_next.ext_e = wd[IC_EXT_E];
				end
				IDX_OPTION: st_next.opt = wd;
				IDX_A_DIR: st_next.a_dir = wd;
				IDX_B_DIR: st_next.b_dir = wd;
				IDX_ANALOG_SELECT: st_next.analog_select = wd;
				IDX_WPU: st_next.wpu = wd;
				IDX_IOC: st_next.ioc = wd[IOC_LO +: 4];
				IDX_OSCSEL: st_next.osc = wd[3:0];
				default: ; // Unmapped writes dropped, idx of a new access kept
			endcase
		end

		// Change flag: set wins over a software clear
		mism = |((st_reg.b_s2[7:4] ^ st_reg.last_rd) & st_reg.ioc);
		edge_hit = st_reg.opt[OPT_EDGE]
			? (st_reg.b_s2[0] && !st_reg.b0_prev)
			: (!st_reg.b_s2[0] && st_reg.b0_prev);
		if (st_reg.pend_wr && st_reg.idx == IDX_INTCTL)
		begin
			st_next.chg_f = wd[IC_CHG_F];
			st_next.ext_f = wd[IC_EXT_F];
		end
		if (mism)
		begin
			st_next.chg_f = 1'b1;
		end
		if (edge_hit)
		begin
			st_next.ext_f = 1'b1;
		end

		// Master-clear or brown-out: all but the compare latch, the data latches
		// and the change flag (loaded with the mismatch) return to reset values
		if (warm_rst)
		begin
			st_next.opt = RST_OPTION;
			st_next.a_dir = RST_DIR;
			st_next.b_dir = RST_DIR;
			st_next.analog_select = RST_ANALOG_SELECT;
			st_next.wpu = RST_WPU;
			st_next.ioc = RST_IOC;
			st_next.osc = 4'h0;
			st_next.chg_e = 1'b0;
			st_next.ext_e = 1'b0;
			st_next.chg_f = mism;
			st_next.ext_f = 1'b0;
			st_next.last_rd = st_reg.last_rd;
		end

		// Wake needs no clock gating here, it is a plain level
		st_next.wake = (st_reg.chg_f && st_reg.chg_e)
			|| (st_reg.ext_f && st_reg.ext_e);

		// Pull-ups: global enable, pin enable, pin is an input
		st_next.pu = {8{!st_reg.opt[OPT_PU_DIS]}} & st_reg.wpu
			& st_reg.b_dir;

		// First port drivers
		st_next.a_pin.out = st_reg.a_lat;
		st_next.a_pin.oe_n = st_reg.a_dir;
		unique case (mode6)
			OSC_GPIO: st_next.a_pin.oe_n[6] = st_reg.a_dir[6];
			OSC_CLK:
			begin
				st_next.a_pin.out[6] = clk_out_src;
				st_next.a_pin.oe_n[6] = 1'b0;
			end
			OSC_XTAL, OSC_TMR: st_next.a_pin.oe_n[6] = 1'b1;
		endcase
		if (mode7 != OSC_GPIO)
		begin
			st_next.a_pin.oe_n[7] = 1'b1;
		end
		st_next.oscin = st_reg.a_s2[7];
		st_next.a_pin.out = (a_lcd.own & a_lcd.val)
			| (~a_lcd.own & st_next.a_pin.out);
		st_next.a_pin.oe_n = (a_lcd.own & a_lcd.hiz)
			| (~a_lcd.own & st_next.a_pin.oe_n);

		// Second port drivers
		st_next.b_pin.out = (b_lcd.own & b_lcd.val)
			| (~b_lcd.own & st_reg.b_lat);
		st_next.b_pin.oe_n = (b_lcd.own & b_lcd.hiz)
			| (~b_lcd.own & st_reg.b_dir);
		if (prog_mode)
		begin
			// Programming owns the data and clock pins
			st_next.b_pin.out[7] = prog_data_out;
			st_next.b_pin.oe_n[7] = !prog_data_drive;
			st_next.b_pin.oe_n[6] = 1'b1;
		end
		st_next.pdi = st_reg.b_s2[7];
		st_next.pclk = st_reg.b_s2[6];
		st_next.pu = st_next.pu & st_next.b_pin.oe_n;
	end

	// ****************************************
	// Registers; power-on reset loads ST_RST into all
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg <= ST_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hrdata = {24'h000000, st_reg.rdata};
	assign hreadyout = st_reg.ready;
	assign hresp = st_reg.pend_rd && !st_reg.pend_rd;
	assign a_pin = st_reg.a_pin;
	assign b_pin = st_reg.b_pin;
	assign b_pullup = st_reg.pu;
	assign prog_data_in = st_reg.pdi;
	assign prog_clk = st_reg.pclk;
	assign osc_in_level = st_reg.oscin;
	assign wake = st_reg.wake;
endmodule : gpp_port_logic

// >>> testbench/gpp_port_monitor.sv
// Assertions on the port logic's bus answer and pin outputs.
// Assumes one clock and a bench that keeps prog_mode low in reset.
`timescale 1ns/1ps
module gpp_port_monitor
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [7:0] a_pin_in,
	input wire logic [7:0] b_pin_in,
	input wire gpp_pkg::gpp_pin_s b_pin,
	input wire logic [7:0] b_pullup,
	input wire logic prog_mode,
	input wire logic prog_data_out,
	input wire logic prog_data_drive,
	input wire logic prog_data_in,
	input wire logic prog_clk,
	input wire logic osc_in_level
);
	import gpp_pkg::*;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ********************
	// Bus answer
	// ********************
	sequence rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	read_wait_a: assert property (rd_taken |=> rd_answer)
		else $error("read answer not one wait state");
	write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	stall_cause_a: assert property ($fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
		else $error("stall without a read");
	// ********************
	// Pins
	// ********************
	pullup_off_a: assert property ((b_pullup & ~b_pin.oe_n) == 8'h00)
		else $error("pull-up on a driven pin");
	// Sync depth checked only once three clean edges have passed
	osc_sync_a: assert property ($past(hresetn, 3) |-> osc_in_level == $past(a_pin_in[7], 3))
		else $error("clock input level wrong");
	prog_clk_a: assert property ($past(hresetn, 3) |-> prog_clk == $past(b_pin_in[6], 3))
		else $error("programming clock level wrong");
	prog_data_a: assert property ($past(hresetn, 3) |-> prog_data_in == $past(b_pin_in[7], 3))
		else $error("programming data level wrong");
	prog_drive_a: assert property ($past(prog_mode && prog_data_drive) |->
		!b_pin.oe_n[7] && b_pin.out[7] == $past(prog_data_out))
		else $error("programming data not driven");
	clk_pin_in_a: assert property ($past(prog_mode) |-> b_pin.oe_n[6])
		else $error("programming clock pin driven");
endmodule : gpp_port_monitor

bind gpp_port_logic gpp_port_monitor mon_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.a_pin_in(a_pin_in), .b_pin_in(b_pin_in), .b_pin(b_pin), .b_pullup(b_pullup),
	.prog_mode(prog_mode), .prog_data_out(prog_data_out), .prog_data_drive(prog_data_drive),
	.prog_data_in(prog_data_in), .prog_clk(prog_clk), .osc_in_level(osc_in_level));

// >>> testbench/gpp_pin_model.sv
// External circuitry: drivers on both ports, pull-ups and floating lines on the second.
// Assumes the bench sets the external levels on clock edges, rising or falling.
`timescale 1ns/1ps
module gpp_pin_model
(
	input wire logic hclk,
	input wire gpp_pkg::gpp_pin_s a_pin,
	input wire gpp_pkg::gpp_pin_s b_pin,
	input wire logic [7:0] b_pullup,
	input wire logic [7:0] a_ext,
	input wire logic [7:0] b_ext,
	input wire logic [7:0] b_ext_en,
	output logic [7:0] a_pin_in,
	output logic [7:0] b_pin_in
);
	import gpp_pkg::*;
	logic tick = 1'b0;
	// Undriven lines wander so a lost drive never reads as a lucky level
	always @(posedge hclk)
		tick <= !tick;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			a_pin_in[i] = !a_pin.oe_n[i] ? a_pin.out[i] : a_ext[i];
			b_pin_in[i] = !b_pin.oe_n[i] ? b_pin.out[i] : b_ext_en[i] ? b_ext[i] :
				b_pullup[i] ? 1'b1 : tick;
		end
	end
endmodule : gpp_pin_model

// >>> testbench/tb_top.sv
// Self-checking bench: register sequences over AHB-Lite, pin effects.
// Assumes the pin model and checker sit beside the design.
`timescale 1ns/1ps
module tb_top;
	import gpp_pkg::*;
	logic hclk, hresetn, warm_rst, hsel, hwrite, hresp, hreadyout, wake;
	logic prog_mode, prog_data_out, prog_data_drive, prog_data_in, prog_clk;
	logic clk_out_src, osc_in_level;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] b_pullup, a_pin_in, b_pin_in, a_ext, b_ext, b_ext_en;
	logic [7:0] ridx [7];
	logic [7:0] rval [7];
	gpp_pin_s a_pin, b_pin;
	gpp_lcd_s a_lcd, b_lcd;
	int n_errors, samples_checked;
	gpp_port_logic gpp_port_logic_i (.hclk(hclk), .hresetn(hresetn), .warm_rst(warm_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .a_pin_in(a_pin_in), .a_pin(a_pin), .b_pin_in(b_pin_in),
		.b_pin(b_pin), .b_pullup(b_pullup), .a_lcd(a_lcd), .b_lcd(b_lcd),
		.clk_out_src(clk_out_src), .prog_mode(prog_mode), .prog_data_out(prog_data_out),
		.prog_data_drive(prog_data_drive), .prog_data_in(prog_data_in),
		.prog_clk(prog_clk), .osc_in_level(osc_in_level), .wake(wake));
	gpp_pin_model gpp_pin_model_i (.hclk(hclk), .a_pin(a_pin), .b_pin(b_pin),
		.b_pullup(b_pullup), .a_ext(a_ext), .b_ext(b_ext), .b_ext_en(b_ext_en),
		.a_pin_in(a_pin_in), .b_pin_in(b_pin_in));
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// ********************
	// Tasks
	// ********************
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Ready is read mid-cycle, where it equals what the next edge samples
	task automatic wait_rdy(output logic [7:0] d);
		logic r;
		r = 1'b0;
		for (int n = 0; n < 40 && r !== 1'b1; n++)
		begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata[7:0];
			@(posedge hclk);
		end
		if (r !== 1'b1)
		begin
			n_errors++;
			close_out();
		end
	endtask : wait_rdy
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] v,
		output logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy(d);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, v};
		wait_rdy(d);
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [7:0] d;
		bus(1'b1, idx, v, d);
	endtask : wr
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
		logic [7:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(nm, e, d);
		chk("hresp", 8'h00, {7'h0, hresp});
	endtask : rchk
	task automatic hold(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask : hold
	// ********************
	// Sequence
	// ********************
	initial
	begin
		{hresetn, warm_rst, hsel, hwrite, prog_mode, prog_data_out, prog_data_drive} = '0;
		{haddr, hwdata, htrans, a_lcd, b_lcd, b_ext} = '0;
		hsize = 3'b010;
		clk_out_src = 1'b0;
		a_ext = 8'h20;
		b_ext_en = 8'hff;
		n_errors = 0;
		samples_checked = 0;
		ridx = '{IDX_OPTION, IDX_A_DIR, IDX_B_DIR, IDX_ANALOG_SELECT, IDX_WPU, IDX_IOC, 8'h40};
		rval = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk("pull-ups", 8'h00, b_pullup);
		chk("a oe_n", 8'hff, a_pin.oe_n);
		for (int i = 0; i < 7; i++) rchk(ridx[i], rval[i], "reset value");
		wr(IDX_ANALOG_SELECT, 8'h00);
		wr(IDX_A_DIR, 8'h30);
		wr(IDX_A_DATA, 8'hc5);
		hold(2);
		chk("a oe_n", 8'h30, a_pin.oe_n);
		chk("a out", 8'hc5, a_pin.out);
		rchk(IDX_A_DATA, 8'he5, "a pins");
		wr(IDX_ANALOG_SELECT, 8'h11);
		rchk(IDX_A_DATA, 8'hc4, "a analog");
		wr(IDX_ANALOG_SELECT, 8'h00);
		for (int m = 1; m < 4; m++)
		begin
			wr(IDX_OSCSEL, {4'h0, m[1:0], m[1:0]});
			hold(3);
			chk("osc oe_n", (m == 2) ? 8'hb0 : 8'hf0, a_pin.oe_n);
			rchk(IDX_A_DATA, 8'h25, "osc pins");
			rchk(IDX_A_DIR, 8'hf0, "osc dir");
		end
		wr(IDX_B_DIR, 8'hf0);
		wr(IDX_B_DATA, 8'h05);
		wr(IDX_WPU, 8'hff);
		wr(IDX_OPTION, 8'h7f);
		b_ext_en <= 8'h00;
		hold(3);
		chk("pull-ups", 8'hf0, b_pullup);
		rchk(IDX_B_DATA, 8'hf5, "pulled pins");
		wr(IDX_WPU, 8'h5f);
		hold(2);
		chk("pull-up bits", 8'h50, b_pullup);
		wr(IDX_OPTION, 8'hff);
		hold(2);
		chk("pull-ups off", 8'h00, b_pullup);
		b_ext_en <= 8'hff;
		wr(IDX_B_DIR, 8'hff);
		wr(IDX_IOC, 8'hf0);
		hold(3);
		rchk(IDX_B_DATA, 8'h00, "b pins");
		wr(IDX_INTCTL, 8'h18);
		rchk(IDX_INTCTL, 8'h18, "no change");
		b_ext <= 8'h09;
		hold(4);
		rchk(IDX_INTCTL, 8'h1a, "edge only");
		wr(IDX_INTCTL, 8'h18);
		b_ext <= 8'h89;
		hold(4);
		chk("wake", 8'h01, {7'h0, wake});
		rchk(IDX_INTCTL, 8'h19, "change flag");
		wr(IDX_INTCTL, 8'h18);
		rchk(IDX_INTCTL, 8'h19, "flag held");
		rchk(IDX_B_DATA, 8'h89, "b pins");
		wr(IDX_INTCTL, 8'h18);
		rchk(IDX_INTCTL, 8'h18, "flag cleared");
		b_ext <= 8'h09;
		hold(4);
		warm_rst <= 1'b1;
		hold(1);
		warm_rst <= 1'b0;
		wr(IDX_IOC, 8'hf0);
		wr(IDX_INTCTL, 8'h00);
		rchk(IDX_INTCTL, 8'h01, "latch kept");
		prog_mode <= 1'b1;
		prog_data_drive <= 1'b1;
		prog_data_out <= 1'b1;
		for (int k = 0; k < 6; k++) hold(1);
		b_ext <= 8'h40;
		hold(4);
		chk("prog oe_n", 8'h40, b_pin.oe_n & 8'hc0);
		prog_mode <= 1'b0;
		b_lcd <= '{own: 8'h02, val: 8'h02, hiz: 8'h00};
		hold(3);
		chk("display drive", 8'h01, {6'h0, b_pin.oe_n[1], b_pin.out[1]});
		b_lcd <= '{own: 8'h02, val: 8'h02, hiz: 8'h02};
		hold(3);
		chk("display hiz", 8'h02, {6'h0, b_pin.oe_n[1], 1'b0});
		close_out();
	end
endmodule : tb_top
